/* jats_pkg.sv */
/*
  Shared constants and types of the test-port selector.
  Assumes a single system clock domain; the test pins are sampled in it.
*/
package jats_pkg;

  localparam int unsigned IR_W       = 5;
  localparam int unsigned CMD_W      = 10;
  localparam int unsigned AUX_N      = 5;
  localparam int unsigned SYNC_N     = 3;

  // Instruction opcodes that select an auxiliary controller.
  localparam logic [4:0] OP_SEL_PORT_CTRL  = 5'h10;
  localparam logic [4:0] OP_SEL_CORE_DEBUG = 5'h11;
  localparam logic [4:0] OP_SEL_TIMER_ENG  = 5'h12;
  localparam logic [4:0] OP_SEL_DMA_DEBUG  = 5'h13;
  localparam logic [4:0] OP_SEL_VBUS_DEBUG = 5'h14;

  // Values after reset and capture, and the select index of the core debug controller.
  localparam logic [4:0] IR_RESET    = 5'h01;
  localparam logic [4:0] IR_CAPTURE  = 5'h01;
  localparam logic [9:0] CMD_RESET   = 10'h202;
  localparam logic [2:0] SEL_NONE    = 3'h7;
  localparam logic [2:0] IDX_CORE    = 3'h1;

  typedef enum logic [3:0] {
    ST_RESET    = 4'h0,
    ST_IDLE     = 4'h1,
    ST_SEL_DR   = 4'h3,
    ST_CAP_DR   = 4'h2,
    ST_SH_DR    = 4'h6,
    ST_EX1_DR   = 4'h7,
    ST_PAU_DR   = 4'h5,
    ST_EX2_DR   = 4'h4,
    ST_UPD_DR   = 4'hC,
    ST_SEL_IR   = 4'hD,
    ST_CAP_IR   = 4'hF,
    ST_SH_IR    = 4'hE,
    ST_EX1_IR   = 4'hA,
    ST_PAU_IR   = 4'hB,
    ST_EX2_IR   = 4'h9,
    ST_UPD_IR   = 4'h8
  } jats_state_t;

endpackage

/* jats_fsm_if.sv */
/*
  Carrier between the selector and one test-port state machine.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps

interface jats_fsm_if;
  logic                 rise;
  logic                 tms;
  logic                 hold;
  logic                 rst;
  jats_pkg::jats_state_t st;
  logic                 ent;

  modport ctl (output rise, output tms, output hold, output rst,
               input st, input ent);
  modport fsm (input rise, input tms, input hold, input rst,
               output st, output ent);
endinterface

/* jats_tap_fsm.sv */
/*
  Sixteen-state test-port state machine stepped by sampled clock rises.
  Assumes rise is a one-cycle strobe and tms is stable with it.
*/
`timescale 1ns/1ps

module jats_tap_fsm (
  input  wire logic   i_sys_clk,
  input  wire logic   i_ce,
  jats_fsm_if.fsm     bus
);

  jats_pkg::jats_state_t st_q;
  jats_pkg::jats_state_t st_d;
  logic                  ent_q;

  ////////////////////////////////////////////////////////////////////////////
  // Next state by TMS.
  always_comb begin
    case (st_q)
      jats_pkg::ST_RESET:  st_d = bus.tms ? jats_pkg::ST_RESET
                                          : jats_pkg::ST_IDLE;
      jats_pkg::ST_IDLE:   st_d = bus.tms ? jats_pkg::ST_SEL_DR
                                          : jats_pkg::ST_IDLE;
      jats_pkg::ST_SEL_DR: st_d = bus.tms ? jats_pkg::ST_SEL_IR
                                          : jats_pkg::ST_CAP_DR;
      jats_pkg::ST_CAP_DR: st_d = bus.tms ? jats_pkg::ST_EX1_DR
                                          : jats_pkg::ST_SH_DR;
      jats_pkg::ST_SH_DR:  st_d = bus.tms ? jats_pkg::ST_EX1_DR
                                          : jats_pkg::ST_SH_DR;
      jats_pkg::ST_EX1_DR: st_d = bus.tms ? jats_pkg::ST_UPD_DR
                                          : jats_pkg::ST_PAU_DR;
      jats_pkg::ST_PAU_DR: st_d = bus.tms ? jats_pkg::ST_EX2_DR
                                          : jats_pkg::ST_PAU_DR;
      jats_pkg::ST_EX2_DR: st_d = bus.tms ? jats_pkg::ST_UPD_DR
                                          : jats_pkg::ST_SH_DR;
      jats_pkg::ST_UPD_DR: st_d = bus.tms ? jats_pkg::ST_SEL_DR
                                          : jats_pkg::ST_IDLE;
      jats_pkg::ST_SEL_IR: st_d = bus.tms ? jats_pkg::ST_RESET
                                          : jats_pkg::ST_CAP_IR;
      jats_pkg::ST_CAP_IR: st_d = bus.tms ? jats_pkg::ST_EX1_IR
                                          : jats_pkg::ST_SH_IR;
      jats_pkg::ST_SH_IR:  st_d = bus.tms ? jats_pkg::ST_EX1_IR
                                          : jats_pkg::ST_SH_IR;
      jats_pkg::ST_EX1_IR: st_d = bus.tms ? jats_pkg::ST_UPD_IR
                                          : jats_pkg::ST_PAU_IR;
      jats_pkg::ST_PAU_IR: st_d = bus.tms ? jats_pkg::ST_EX2_IR
                                          : jats_pkg::ST_PAU_IR;
      jats_pkg::ST_EX2_IR: st_d = bus.tms ? jats_pkg::ST_UPD_IR
                                          : jats_pkg::ST_SH_IR;
      jats_pkg::ST_UPD_IR: st_d = bus.tms ? jats_pkg::ST_SEL_DR
                                          : jats_pkg::ST_IDLE;
      default:             st_d = jats_pkg::ST_RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold steers the machine to idle.
  always_ff @(posedge i_sys_clk) begin
    if (bus.rst) begin
      st_q  <= jats_pkg::ST_RESET;
      ent_q <= 1'b0;
    end else if (i_ce) begin
      if (bus.hold) begin
        st_q  <= jats_pkg::ST_IDLE;
        ent_q <= 1'b0;
      end else if (bus.rise) begin
        st_q  <= st_d;
        ent_q <= 1'b1;
      end else begin
        ent_q <= 1'b0;
      end
    end
  end

  assign bus.st  = st_q;
  assign bus.ent = ent_q;

endmodule

/* jats_aux_tap_select.sv */
/*
  Test-port controller that shares the test pins with auxiliary controllers
  and holds the core debug command register.
  Assumes the test clock is slow against i_sys_clk and arrives as a pin.
*/
`timescale 1ns/1ps

module jats_aux_tap_select #(
  parameter int unsigned AUX_N = jats_pkg::AUX_N
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic             i_tck,
  input  wire logic             i_tms,
  input  wire logic             i_tdi,
  input  wire logic             i_tap_compliance_enable,
  input  wire logic [AUX_N-1:0] i_aux_tdo,
  input  wire logic             i_core_dr_tdo,
  output logic                  o_tdo,
  output logic                  o_tdo_oe,
  output logic                  o_aux_tck_rise,
  output logic                  o_aux_tck_fall,
  output logic                  o_aux_tms,
  output logic                  o_aux_tdi,
  output logic [AUX_N-1:0]      o_aux_select,
  output logic [AUX_N-1:0]      o_aux_hold_idle,
  output logic [9:0]            o_core_debug_command_reg,
  output logic                  o_core_dr_shift,
  output logic                  o_ctrl_in_reset
);

  jats_fsm_if main_if ();
  jats_fsm_if core_if ();

  logic [2:0]           tck_s_q;
  logic [2:0]           tms_s_q;
  logic [2:0]           tdi_s_q;
  logic [2:0]           cmp_s_q;
  logic                 tms_q;
  logic                 tdi_q;
  logic                 cmp_q;
  logic                 rise;
  logic                 fall;
  logic                 hard_rst;
  logic [4:0]           ir_sh_q;
  logic [4:0]           ir_q;
  logic [2:0]           sel_q;
  logic                 pause_q;
  logic                 bypass_q;
  logic [9:0]           cmd_sh_q;
  logic [9:0]           cmd_q;
  logic                 tdo_d;
  logic                 oe_d;
  logic                 tdo_q;
  logic                 oe_q;
  logic                 own;

  function automatic logic is_sel_op(input logic [4:0] op);
    return (op >= jats_pkg::OP_SEL_PORT_CTRL) &&
           (op <= jats_pkg::OP_SEL_VBUS_DEBUG);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling, three stages each.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tck_s_q <= 3'h0;
      tms_s_q <= 3'h7;
      tdi_s_q <= 3'h0;
      cmp_s_q <= 3'h0;
      tms_q   <= 1'b1;
      tdi_q   <= 1'b0;
      cmp_q   <= 1'b0;
    end else if (i_ce) begin
      tck_s_q <= {tck_s_q[1:0], i_tck};
      tms_s_q <= {tms_s_q[1:0], i_tms};
      tdi_s_q <= {tdi_s_q[1:0], i_tdi};
      cmp_s_q <= {cmp_s_q[1:0], i_tap_compliance_enable};
      if (tms_s_q[1] == tms_s_q[2]) tms_q <= tms_s_q[2];
      if (tdi_s_q[1] == tdi_s_q[2]) tdi_q <= tdi_s_q[2];
      if (cmp_s_q[1] == cmp_s_q[2]) cmp_q <= cmp_s_q[2];
    end
  end

  // Edges of the sampled test clock.
  assign rise = tck_s_q[1] & ~tck_s_q[2];
  assign fall = ~tck_s_q[1] & tck_s_q[2];

  // Forced reset without a clock edge.
  assign hard_rst = i_rst | ~cmp_q;

  assign main_if.rise = rise;
  assign main_if.tms  = tms_q;
  assign main_if.hold = 1'b0;
  assign main_if.rst  = hard_rst;

  jats_tap_fsm u_main (
    .i_sys_clk (i_sys_clk),
    .i_ce      (i_ce),
    .bus       (main_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register of the controller.
  always_ff @(posedge i_sys_clk) begin
    if (hard_rst || main_if.st == jats_pkg::ST_RESET) begin
      ir_sh_q <= jats_pkg::IR_RESET;
      ir_q    <= jats_pkg::IR_RESET;
    end else if (i_ce && own) begin
      if (rise && main_if.st == jats_pkg::ST_CAP_IR) begin
        ir_sh_q <= jats_pkg::IR_CAPTURE;
      end else if (rise && main_if.st == jats_pkg::ST_SH_IR) begin
        ir_sh_q <= {tdi_q, ir_sh_q[4:1]};
      end
      if (main_if.ent && main_if.st == jats_pkg::ST_UPD_IR) begin
        ir_q <= ir_sh_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ownership of the test pins.
  always_ff @(posedge i_sys_clk) begin
    // Controller owns the pins after reset.
    if (hard_rst || main_if.st == jats_pkg::ST_RESET) begin
      sel_q <= jats_pkg::SEL_NONE;
    end else if (i_ce) begin
      if (own && main_if.ent && main_if.st == jats_pkg::ST_UPD_IR) begin
        if (cmp_q && is_sel_op(ir_sh_q)) begin
          sel_q <= 3'(ir_sh_q - jats_pkg::OP_SEL_PORT_CTRL);
        end else begin
          sel_q <= jats_pkg::SEL_NONE;
        end
      end else if (!own && main_if.ent && pause_q &&
                   main_if.st == jats_pkg::ST_UPD_DR) begin
        sel_q <= jats_pkg::SEL_NONE;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (hard_rst) begin
      pause_q <= 1'b0;
    end else if (i_ce && main_if.ent) begin
      if (main_if.st == jats_pkg::ST_CAP_DR) pause_q <= 1'b0;
      else if (main_if.st == jats_pkg::ST_PAU_DR) pause_q <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (hard_rst) begin
      bypass_q <= 1'b0;
    end else if (i_ce && rise) begin
      if (main_if.st == jats_pkg::ST_CAP_DR) bypass_q <= 1'b0;
      else if (main_if.st == jats_pkg::ST_SH_DR) bypass_q <= tdi_q;
    end
  end

  assign own = (sel_q == jats_pkg::SEL_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // Core debug controller and its command register.
  assign core_if.rise = rise;
  assign core_if.tms  = tms_q;
  assign core_if.hold = (sel_q != jats_pkg::IDX_CORE);
  assign core_if.rst  = hard_rst;

  jats_tap_fsm u_core (
    .i_sys_clk (i_sys_clk),
    .i_ce      (i_ce),
    .bus       (core_if)
  );

  always_ff @(posedge i_sys_clk) begin
    if (hard_rst || main_if.st == jats_pkg::ST_RESET ||
        core_if.st == jats_pkg::ST_RESET) begin
      cmd_sh_q <= jats_pkg::CMD_RESET;
      cmd_q    <= jats_pkg::CMD_RESET;
    end else if (i_ce && !core_if.hold) begin
      if (rise && core_if.st == jats_pkg::ST_SH_IR) begin
        cmd_sh_q <= {tdi_q, cmd_sh_q[9:1]};
      end
      if (core_if.ent && core_if.st == jats_pkg::ST_UPD_IR) begin
        cmd_q <= cmd_sh_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output, changed on the falling test clock.
  always_comb begin
    tdo_d = 1'b0;
    oe_d  = 1'b0;
    if (own) begin
      oe_d  = (main_if.st == jats_pkg::ST_SH_IR) ||
              (main_if.st == jats_pkg::ST_SH_DR);
      tdo_d = (main_if.st == jats_pkg::ST_SH_IR) ? ir_sh_q[0] : bypass_q;
    end else if (sel_q == jats_pkg::IDX_CORE) begin
      oe_d  = (core_if.st == jats_pkg::ST_SH_IR) ||
              (core_if.st == jats_pkg::ST_SH_DR);
      tdo_d = (core_if.st == jats_pkg::ST_SH_IR) ? cmd_sh_q[0]
                                                 : i_core_dr_tdo;
    end else begin
      oe_d  = 1'b1;
      tdo_d = i_aux_tdo[sel_q];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (hard_rst) begin
      tdo_q <= 1'b0;
      oe_q  <= 1'b0;
    end else if (i_ce && fall) begin
      tdo_q <= tdo_d;
      oe_q  <= oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing to the auxiliary controllers.
  genvar g;
  generate
    for (g = 0; g < AUX_N; g++) begin : g_aux
      assign o_aux_select[g]    = (sel_q == 3'(g));
      assign o_aux_hold_idle[g] = (sel_q != 3'(g));
    end
  endgenerate

  assign o_tdo                    = tdo_q;
  assign o_tdo_oe                 = oe_q;
  assign o_aux_tck_rise           = rise & ~own;
  assign o_aux_tck_fall           = fall & ~own;
  assign o_aux_tms                = own ? 1'b0 : tms_q;
  assign o_aux_tdi                = own ? 1'b0 : tdi_q;
  assign o_core_debug_command_reg = cmd_q;
  assign o_core_dr_shift          = (sel_q == jats_pkg::IDX_CORE) &&
                                    (core_if.st == jats_pkg::ST_SH_DR);
  assign o_ctrl_in_reset          = hard_rst ||
                                    (main_if.st == jats_pkg::ST_RESET);

endmodule

/* jats_aux_tap_select_assertions.sv */
/* Checker on the ports of the test-port selector.
   Assumes a bind into jats_aux_tap_select and slow TCK half periods. */
`timescale 1ns/1ps
module jats_sel_chk #(
  parameter int unsigned AUX_N = 5
) (
  input wire logic             i_sys_clk,
  input wire logic             i_rst,
  input wire logic             i_tck,
  input wire logic             i_tap_compliance_enable,
  input wire logic             o_tdo,
  input wire logic             o_aux_tck_rise,
  input wire logic             o_aux_tck_fall,
  input wire logic             o_aux_tms,
  input wire logic             o_aux_tdi,
  input wire logic [AUX_N-1:0] o_aux_select,
  input wire logic [AUX_N-1:0] o_aux_hold_idle,
  input wire logic [9:0]       o_core_debug_command_reg,
  input wire logic             o_core_dr_shift,
  input wire logic             o_ctrl_in_reset
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////
  a_hold_inverse: assert property (
    o_aux_hold_idle == ~o_aux_select) else $error("hold not inverse");
  a_sel_onehot: assert property (
    $onehot0(o_aux_select)) else $error("select not one-hot");
  a_rst_release: assert property (
    $fell(i_rst) |-> o_aux_select == '0 && o_ctrl_in_reset)
    else $error("select after reset");
  a_cmd_in_reset: assert property (
    o_ctrl_in_reset && $past(o_ctrl_in_reset) |->
    o_core_debug_command_reg == jats_pkg::CMD_RESET)
    else $error("command not reset");
  a_comp_low: assert property (
    !i_tap_compliance_enable [*6] |-> o_ctrl_in_reset && o_aux_select == '0)
    else $error("compliance low not reset");
  a_sel_needs_comp: assert property (
    $rose(|o_aux_select) |-> i_tap_compliance_enable && !o_ctrl_in_reset)
    else $error("select without compliance");
  a_route_owner: assert property (
    o_aux_select == '0 && $past(o_aux_select) == '0 |->
    !(o_aux_tck_rise || o_aux_tck_fall || o_aux_tms || o_aux_tdi))
    else $error("pins routed while unselected");
  a_rise_pulse: assert property (
    o_aux_tck_rise |-> $past(i_tck) ##1 !o_aux_tck_rise)
    else $error("rise pulse wrong");
  a_tdo_on_fall: assert property (
    $changed(o_tdo) && !o_ctrl_in_reset && !$past(o_ctrl_in_reset) |->
    !$past(i_tck, 2)) else $error("tdo changed off fall");
  a_core_shift: assert property (
    o_core_dr_shift |-> o_aux_select == AUX_N'(2))
    else $error("core shift unselected");
  c_select: cover property ($rose(o_aux_select[1]));
  c_return: cover property ($fell(|o_aux_select) && !o_ctrl_in_reset);
  c_core_shift: cover property (o_core_dr_shift);
endmodule

bind jats_aux_tap_select jats_sel_chk #(.AUX_N(AUX_N)) u_jats_sel_chk (
  .i_sys_clk, .i_rst, .i_tck, .i_tap_compliance_enable, .o_tdo,
  .o_aux_tck_rise, .o_aux_tck_fall, .o_aux_tms, .o_aux_tdi, .o_aux_select,
  .o_aux_hold_idle, .o_core_debug_command_reg, .o_core_dr_shift,
  .o_ctrl_in_reset);

/* jats_jtag_tool.sv */
/* Model of the external debug tool driving the test pins.
   Assumes TCK idles low between frames, 160 ns each half period. */
`timescale 1ns/1ps
module jats_jtag_tool (
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe
);
  logic last = 1'b0;
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // serial ticks.
  // Pins change after a fall; an undriven TDO reads as the inverse of the bit sampled before it.
  task automatic scan(input int n, input logic [15:0] tms_v, tdi_v,
                      output logic [15:0] tdo_v);
    tdo_v = '0;
    for (int i = 0; i < n; i++) begin
      o_tms = tms_v[i];
      o_tdi = tdi_v[i];
      #160 o_tck = 1'b1;
      tdo_v[i] = i_tdo_oe ? i_tdo : ~last;
      last = tdo_v[i];
      #160 o_tck = 1'b0;
    end
  endtask
endmodule

/* jats_aux_tap_select_test.sv */
/* Self-checking bench of the test-port selector.
   Assumes the tool model owns TCK, TMS and TDI. */
`timescale 1ns/1ps
module jats_aux_tap_select_test;
  logic        clk          = 1'b0;
  logic        rst          = 1'b1;
  logic        comp         = 1'b0;
  logic        ce           = 1'b1;
  logic        core_tdo     = 1'b0;
  logic [4:0]  aux_tdo      = 5'h00;
  logic [4:0]  op;
  logic [9:0]  cv;
  logic [15:0] cap;
  logic        r;
  int          err_count    = 0;
  int          total_checks = 0;
  int          seed         = 63;
  wire         tck, tms, tdi, tdo, oe, atms, atdi, dsh, inr;
  wire  [4:0]  sel, hold;
  wire  [9:0]  cmd;

  always #20 clk = ~clk;

  jats_aux_tap_select u_jats_aux_tap_select (
    .i_sys_clk(clk), .i_rst(rst), .i_ce(ce), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .i_tap_compliance_enable(comp), .i_aux_tdo(aux_tdo),
    .i_core_dr_tdo(core_tdo), .o_tdo(tdo), .o_tdo_oe(oe),
    .o_aux_tck_rise(), .o_aux_tck_fall(), .o_aux_tms(atms),
    .o_aux_tdi(atdi), .o_aux_select(sel), .o_aux_hold_idle(hold),
    .o_core_debug_command_reg(cmd), .o_core_dr_shift(dsh),
    .o_ctrl_in_reset(inr));
  jats_jtag_tool u_jats_jtag_tool (
    .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe(oe));
  ////////////////////////////////////////////////////////////////
  function automatic logic [4:0] sel_of(input logic [4:0] o);
    return (o >= 5'h10 && o <= 5'h14) ? 5'h01 << (o - 5'h10) : 5'h00;
  endfunction
  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic st;
    repeat (6) @(negedge clk);
  endtask
  task automatic sc(input int n, input logic [15:0] m, d);
    u_jats_jtag_tool.scan(n, m, d, cap);
    st;
  endtask
  // Instruction scan from idle: n bits LSB first, TMS high on the last.
  task automatic ir(input int n, input logic [9:0] v);
    sc(n + 6, 16'h3 | (16'h3 << (n + 3)), 16'(v) << 4);
  endtask
  initial begin
    #1000000;
    err_count++;
    end_of_test;
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    comp = 1'b1;
    st;
    chk(inr, 1'b1);
    chk(sel, 5'h00);
    chk(hold, 5'h1F);
    chk(cmd, jats_pkg::CMD_RESET);
    chk(oe, 1'b0);
    sc(1, 16'h0, 16'h0);
    chk(inr, 1'b0);
    sc(3, 16'h1, 16'h0);
    sc(4, 16'hF, 16'h0);
    chk(inr, 1'b0);
    sc(1, 16'h1, 16'h0);
    chk(inr, 1'b1);
    sc(1, 16'h0, 16'h0);
    for (int k = 16; k <= 20; k++) begin
      op = 5'(k);
      ir(5, 10'(op));
      chk(cap[8:4], jats_pkg::IR_CAPTURE);
      chk(sel, sel_of(op));
      chk(hold, 5'(~sel_of(op)));
      @(negedge clk);
      aux_tdo = 5'($random(seed));
      r = 1'($random(seed));
      core_tdo = ~r;
      sc(1, 16'h0, {15'h0, r});
      chk(atdi, r);
      chk(atms, 1'b0);
      if (k != 17) chk(tdo, aux_tdo[k-16]);
      if (k == 17) begin
        cv = 10'($random(seed));
        ir(10, cv);
        chk(cmd, cv);
      end
      sc(6, 16'h19, 16'h0);
      chk(sel, sel_of(op));
      sc(3, 16'h1, 16'h0);
      chk(dsh, k == 17);
      chk(tdo, k == 17 ? 1'(~r) : aux_tdo[k-16]);
      sc(5, 16'hD, 16'h0);
      chk(sel, 5'h00);
      chk(hold, 5'h1F);
    end
    ir(5, 10'h15);
    chk(sel, 5'h00);
    repeat (6) begin
      op = 5'($random(seed));
      if (op inside {[5'h10:5'h14]}) op = ~op;
      ir(5, 10'(op));
      chk(sel, 5'h00);
    end
    ir(5, 10'h11);
    @(negedge clk);
    comp = 1'b0;
    repeat (6) @(negedge clk);
    chk(inr, 1'b1);
    chk(sel, 5'h00);
    chk(cmd, jats_pkg::CMD_RESET);
    sc(1, 16'h0, 16'h0);
    ir(5, 10'h11);
    chk(sel, 5'h00);
    comp = 1'b1;
    st;
    sc(1, 16'h0, 16'h0);
    ir(5, 10'h11);
    chk(sel, 5'h02);
    ce = 1'b0;
    sc(3, 16'h1, 16'h0);
    ce = 1'b1;
    st;
    chk(dsh, 1'b0);
    chk(sel, 5'h02);
    sc(3, 16'h1, 16'h0);
    chk(dsh, 1'b1);
    end_of_test;
  end
endmodule
